/* bulk_loop_pkg.sv */
package bulk_loop_pkg;
  localparam int ADDR_W = 8;
  localparam int BC_W = 10;
  localparam logic [7:0] OFS_COUNT_BASE = 8'h10;
  localparam logic [7:0] OFS_EP_STATUS = 8'h30;
  localparam logic [7:0] OFS_NAK_EN = 8'h34;
  localparam logic [7:0] OFS_NAK_REQ = 8'h38;
  localparam logic [7:0] OFS_IN_NAK_EN = 8'h3C;
  localparam logic [7:0] OFS_IN_NAK_REQ = 8'h40;
  localparam logic [7:0] OFS_APTR_SETUP = 8'h44;
  localparam logic [7:0] OFS_APTR_ONE = 8'h48;
  localparam logic [7:0] OFS_APTR_TWO = 8'h4C;
  localparam logic [7:0] OFS_APTR_ONE_DATA = 8'h50;
  localparam logic [7:0] OFS_APTR_TWO_DATA = 8'h54;
  localparam int SKIP_BIT = 7;
  localparam int PING_BIT = 4;
  localparam int APTR_INC_BIT = 0;
  localparam logic [7:0] CFG_RST = 8'h00;
  localparam logic [7:0] APTR_SETUP_RST = 8'h01;
  localparam logic [1:0] AXI_OKAY = 2'h0;
  localparam logic [1:0] AXI_SLVERR = 2'h2;
  typedef enum logic [1:0] {TOK_OUT = 2'b00, TOK_IN = 2'b01, TOK_PING = 2'b10} tok_kind_type;
  typedef enum logic [1:0] {HS_ACK = 2'b00, HS_NAK = 2'b01, HS_DATA = 2'b10} hs_type;
  typedef enum logic [1:0] {
    LINK_IDLE = 2'b00, LINK_RX = 2'b01, LINK_DROP = 2'b10, LINK_TX = 2'b11
  } link_state_type;
  typedef struct packed {
    logic tok_valid;
    tok_kind_type tok_kind;
    logic tok_pair;
    logic byte_valid;
    logic [7:0] byte_data;
    logic byte_last;
  } link_in_type;
  typedef struct packed {
    logic hs_valid;
    hs_type hs_code;
    logic [BC_W-1:0] in_count;
    logic in_valid;
    logic [7:0] in_data;
    logic in_last;
  } link_out_type;
endpackage

/* bulk_loop_endpoints.sv */
`timescale 1ns/1ps
module bulk_loop_endpoints #(
  parameter int BUF_LOG2 = 9
) (
  input wire logic aclk, // 20 MHz
  input wire logic aresetn, // sync reset
  input wire logic [bulk_loop_pkg::ADDR_W-1:0] awaddr, // write address
  input wire logic awvalid, // write address valid
  output logic awready, // write address ready
  input wire logic [31:0] wdata, // write data
  input wire logic [3:0] wstrb, // byte lanes
  input wire logic wvalid, // write data valid
  output logic wready, // write data ready
  output logic [1:0] bresp, // write response
  output logic bvalid, // write response valid
  input wire logic bready, // write response ready
  input wire logic [bulk_loop_pkg::ADDR_W-1:0] araddr, // read address
  input wire logic arvalid, // read address valid
  output logic arready, // read address ready
  output logic [31:0] rdata, // read data
  output logic [1:0] rresp, // read response
  output logic rvalid, // read data valid
  input wire logic rready, // read data ready
  input wire bulk_loop_pkg::link_in_type link_in, // tokens and OUT bytes
  output bulk_loop_pkg::link_out_type link_out, // handshakes and IN bytes
  output logic irq // enabled request pending
);
  import bulk_loop_pkg::*;
  localparam int MEM_AW = BUF_LOG2 + 3;

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // ****************************************
  // bus slave
  // ****************************************
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q, aw_have_q, w_have_q;
  logic [ADDR_W-1:0] wa_q;
  logic [31:0] wd_q, rdata_q, rd_val;
  logic [3:0] ws_q;
  logic [1:0] bresp_q, rresp_q;
  logic wr_fire, wr_lo, wr_cnt, wr_low, rd_fire, rd_ok;
  logic [7:0] cofs, rofs;
  logic [1:0] wr_ep;

  assign wr_fire = aw_have_q && w_have_q && !bvalid_q;
  assign wr_lo = wr_fire && ws_q[0];
  assign cofs = wa_q - OFS_COUNT_BASE;
  assign wr_cnt = wa_q >= OFS_COUNT_BASE && wa_q < OFS_EP_STATUS;
  assign wr_ep = cofs[4:3];
  assign wr_low = cofs[2];
  assign rd_fire = arvalid && arready_q;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      awready_q <= 1'b1;
      wready_q <= 1'b1;
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      bvalid_q <= 1'b0;
      bresp_q <= AXI_OKAY;
      wa_q <= '0;
      wd_q <= '0;
      ws_q <= '0;
    end else begin
      if (awvalid && awready_q) begin
        aw_have_q <= 1'b1;
        awready_q <= 1'b0;
        wa_q <= awaddr;
      end
      if (wvalid && wready_q) begin
        w_have_q <= 1'b1;
        wready_q <= 1'b0;
        wd_q <= wdata;
        ws_q <= wstrb;
      end
      if (wr_fire) begin
        bvalid_q <= 1'b1;
        bresp_q <= (wa_q[1:0] == 2'h0 && wa_q <= OFS_APTR_TWO_DATA) ? AXI_OKAY : AXI_SLVERR;
        aw_have_q <= 1'b0;
        w_have_q <= 1'b0;
      end
      if (bvalid_q && bready) begin
        bvalid_q <= 1'b0;
        awready_q <= 1'b1;
        wready_q <= 1'b1;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b1;
      rvalid_q <= 1'b0;
      rdata_q <= '0;
      rresp_q <= AXI_OKAY;
    end else begin
      if (rd_fire) begin
        arready_q <= 1'b0;
        rvalid_q <= 1'b1;
        rdata_q <= rd_val;
        rresp_q <= rd_ok ? AXI_OKAY : AXI_SLVERR;
      end
      if (rvalid_q && rready) begin
        rvalid_q <= 1'b0;
        arready_q <= 1'b1;
      end
    end
  end

  assign awready = awready_q;
  assign wready = wready_q;
  assign bvalid = bvalid_q;
  assign bresp = bresp_q;
  assign arready = arready_q;
  assign rvalid = rvalid_q;
  assign rdata = rdata_q;
  assign rresp = rresp_q;

  // ****************************************
  // endpoint state
  // ****************************************
  link_state_type lstate_q;
  logic lpair_q;
  logic [BC_W-1:0] loff_q, lcnt_q;
  link_out_type link_out_q;
  logic [7:0] cfg_q [4];
  logic [1:0] out_avail_q [2];
  logic [1:0] out_full_q [2];
  logic [1:0] in_comm_q [2];
  logic out_wbuf_q [2];
  logic out_rbuf_q [2];
  logic in_wbuf_q [2];
  logic in_rbuf_q [2];
  logic [1:0] in_hi_q [2];
  logic [BC_W-1:0] out_cnt_q [2][2];
  logic [BC_W-1:0] in_cnt_q [2][2];
  logic [1:0] ping_req_v, ping_en_v, in_req_v, in_en_v;
  logic [1:0] skip_ev, commit_ev, out_acc, ping_nak, in_nak, drain;
  logic [7:0] stat;
  logic tx_last;

  assign tx_last = loff_q == lcnt_q - 10'(1);

  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_pair
      logic tok_here, rx_done, sk_data, sk_arm, com_ok;
      logic [2:0] occupied;
      assign tok_here = link_in.tok_valid && lstate_q == LINK_IDLE && link_in.tok_pair == g;
      assign skip_ev[g] = wr_lo && wr_cnt && wr_low && wr_ep == 2'(g) && wd_q[SKIP_BIT];
      assign commit_ev[g] = wr_lo && wr_cnt && wr_low && wr_ep == 2'(g + 2);
      assign out_acc[g] = tok_here && link_in.tok_kind == TOK_OUT && out_avail_q[g] != 2'h0;
      assign ping_nak[g] = tok_here && link_in.tok_kind == TOK_PING && out_avail_q[g] == 2'h0;
      assign in_nak[g] = tok_here && link_in.tok_kind == TOK_IN && in_comm_q[g] == 2'h0;
      assign rx_done = lstate_q == LINK_RX && lpair_q == g && link_in.byte_valid
        && link_in.byte_last;
      assign drain[g] = (tok_here && link_in.tok_kind == TOK_IN && in_comm_q[g] != 2'h0
        && in_cnt_q[g][in_rbuf_q[g]] == '0) || (lstate_q == LINK_TX && lpair_q == g && tx_last);
      assign occupied = 3'(out_avail_q[g]) + 3'(out_full_q[g])
        + 3'(lstate_q == LINK_RX && lpair_q == g);
      assign sk_data = skip_ev[g] && out_full_q[g] != 2'h0;
      assign sk_arm = skip_ev[g] && out_full_q[g] == 2'h0 && occupied < 3'd2;
      assign com_ok = commit_ev[g] && in_comm_q[g] != 2'h2;
      assign stat[2*g] = out_full_q[g] == 2'h0;
      assign stat[2*g+1] = out_avail_q[g] == 2'h0;
      assign stat[2*g+4] = in_comm_q[g] == 2'h0;
      assign stat[2*g+5] = in_comm_q[g] == 2'h2;

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          out_avail_q[g] <= 2'h0;
          out_full_q[g] <= 2'h0;
          out_wbuf_q[g] <= 1'b0;
          out_rbuf_q[g] <= 1'b0;
          out_cnt_q[g][0] <= '0;
          out_cnt_q[g][1] <= '0;
        end else begin
          out_avail_q[g] <= out_avail_q[g] + 2'(sk_data || sk_arm) - 2'(out_acc[g]);
          out_full_q[g] <= out_full_q[g] + 2'(rx_done) - 2'(sk_data);
          if (sk_data) begin
            out_rbuf_q[g] <= !out_rbuf_q[g];
          end
          if (rx_done) begin
            out_wbuf_q[g] <= !out_wbuf_q[g];
            out_cnt_q[g][out_wbuf_q[g]] <= loff_q + 10'(1);
          end
        end
      end

      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          in_comm_q[g] <= 2'h0;
          in_wbuf_q[g] <= 1'b0;
          in_rbuf_q[g] <= 1'b0;
          in_hi_q[g] <= 2'h0;
          in_cnt_q[g][0] <= '0;
          in_cnt_q[g][1] <= '0;
        end else begin
          in_comm_q[g] <= in_comm_q[g] + 2'(com_ok) - 2'(drain[g]);
          if (wr_lo && wr_cnt && !wr_low && wr_ep == 2'(g + 2)) begin
            in_hi_q[g] <= wd_q[1:0];
          end
          if (com_ok) begin
            in_wbuf_q[g] <= !in_wbuf_q[g];
            in_cnt_q[g][in_wbuf_q[g]] <= {in_hi_q[g], wd_q[7:0]};
          end
          if (drain[g]) begin
            in_rbuf_q[g] <= !in_rbuf_q[g];
          end
        end
      end

      // set wins over a simultaneous clear
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          ping_req_v[g] <= 1'b0;
          in_req_v[g] <= 1'b0;
          ping_en_v[g] <= 1'b0;
          in_en_v[g] <= 1'b0;
        end else begin
          if (ping_nak[g]) begin
            ping_req_v[g] <= 1'b1;
          end else if (wr_lo && wa_q == OFS_NAK_REQ && wd_q[PING_BIT+g]) begin
            ping_req_v[g] <= 1'b0;
          end
          if (in_nak[g]) begin
            in_req_v[g] <= 1'b1;
          end else if (wr_lo && wa_q == OFS_IN_NAK_REQ && wd_q[g]) begin
            in_req_v[g] <= 1'b0;
          end
          if (wr_lo && wa_q == OFS_NAK_EN) begin
            ping_en_v[g] <= wd_q[PING_BIT+g];
          end
          if (wr_lo && wa_q == OFS_IN_NAK_EN) begin
            in_en_v[g] <= wd_q[g];
          end
        end
      end

      sequence ping_when_full;
        tok_here && link_in.tok_kind == TOK_PING && out_avail_q[g] == 2'h0;
      endsequence
      a_out_two_max: assert property ((3'(out_avail_q[g]) + 3'(out_full_q[g])) <= 3'd2)
        else $error("OUT endpoint holds more than two buffers");
      a_full_out_nak: assert property (tok_here && link_in.tok_kind == TOK_OUT
        && out_avail_q[g] == 2'h0 |=> link_out_q.hs_valid && link_out_q.hs_code == HS_NAK
        ##1 lstate_q == LINK_DROP || lstate_q == LINK_IDLE)
        else $error("OUT to full endpoint not refused");
      a_in_nak_req: assert property (in_nak[g] |=> in_req_v[g]
        && link_out_q.hs_code == HS_NAK)
        else $error("IN NAK did not raise request");
      a_skip_frees: assert property (sk_data && !out_acc[g] |=>
        out_avail_q[g] == 2'($past(out_avail_q[g]) + 2'h1))
        else $error("skip did not free a buffer");
      a_commit_adds: assert property (com_ok && !drain[g] |=>
        in_comm_q[g] == 2'($past(in_comm_q[g]) + 2'h1))
        else $error("commit did not add a packet");
      a_ping_nak_irq: assert property (ping_when_full |=> ping_req_v[g]
        && link_out_q.hs_code == HS_NAK)
        else $error("PING NAK without request");
      a_ping_ack_free: assert property (tok_here && link_in.tok_kind == TOK_PING
        && out_avail_q[g] != 2'h0 |=> link_out_q.hs_code == HS_ACK)
        else $error("PING not acknowledged with free buffer");
      a_req_sticky: assert property (in_req_v[g] && !(wr_fire && wa_q == OFS_IN_NAK_REQ)
        |=> in_req_v[g])
        else $error("IN NAK request dropped");
    end
  endgenerate

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      irq <= 1'b0;
    end else begin
      irq <= |(in_req_v & in_en_v) || |(ping_req_v & ping_en_v);
    end
  end

  // ****************************************
  // buffer memory and autopointers
  // ****************************************
  logic [7:0] mem [2**MEM_AW];
  logic [15:0] ptr1_q, ptr2_q;
  logic [7:0] aptr_setup_q;
  logic [MEM_AW-1:0] ap1_addr, ap2_addr, rx_addr, tx_addr;
  logic [1:0] win1, win2;
  logic ap1_rd, ap2_wr, rx_wr;

  function automatic logic [MEM_AW-1:0] win_addr(input logic [15:0] p, input logic [1:0] w,
                                                 input logic b);
    win_addr = {w, b, p[BUF_LOG2-1:0]};
  endfunction

  // each window maps to the buffer that firmware currently owns
  assign win1 = ptr1_q[BUF_LOG2+1:BUF_LOG2];
  assign win2 = ptr2_q[BUF_LOG2+1:BUF_LOG2];
  assign ap1_addr = win_addr(ptr1_q, win1,
    win1[1] ? in_wbuf_q[win1[0]] : out_rbuf_q[win1[0]]);
  assign ap2_addr = win_addr(ptr2_q, win2,
    win2[1] ? in_wbuf_q[win2[0]] : out_rbuf_q[win2[0]]);
  assign rx_addr = {1'b0, lpair_q, out_wbuf_q[lpair_q], loff_q[BUF_LOG2-1:0]};
  assign tx_addr = {1'b1, lpair_q, in_rbuf_q[lpair_q], loff_q[BUF_LOG2-1:0]};
  assign ap1_rd = rd_fire && araddr == OFS_APTR_ONE_DATA;
  assign ap2_wr = wr_lo && wa_q == OFS_APTR_TWO_DATA;
  assign rx_wr = lstate_q == LINK_RX && link_in.byte_valid && !loff_q[BUF_LOG2];

  always_ff @(posedge aclk) begin
    if (rx_wr) begin
      mem[rx_addr] <= link_in.byte_data;
    end
    if (ap2_wr) begin
      mem[ap2_addr] <= wd_q[7:0];
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ptr1_q <= '0;
      ptr2_q <= '0;
      aptr_setup_q <= APTR_SETUP_RST;
    end else begin
      if (wr_lo && wa_q == OFS_APTR_SETUP) begin
        aptr_setup_q <= wd_q[7:0];
      end
      if (wr_fire && wa_q == OFS_APTR_ONE) begin
        ptr1_q <= {ws_q[1] ? wd_q[15:8] : ptr1_q[15:8], ws_q[0] ? wd_q[7:0] : ptr1_q[7:0]};
      end else if (ap1_rd && aptr_setup_q[APTR_INC_BIT]) begin
        ptr1_q <= ptr1_q + 16'h0001;
      end
      if (wr_fire && wa_q == OFS_APTR_TWO) begin
        ptr2_q <= {ws_q[1] ? wd_q[15:8] : ptr2_q[15:8], ws_q[0] ? wd_q[7:0] : ptr2_q[7:0]};
      end else if (ap2_wr && aptr_setup_q[APTR_INC_BIT]) begin
        ptr2_q <= ptr2_q + 16'h0001;
      end
    end
  end

  a_aptr_step: assert property (@(posedge aclk) disable iff (!aresetn)
    ap1_rd && aptr_setup_q[APTR_INC_BIT] && !(wr_fire && wa_q == OFS_APTR_ONE)
    |=> ptr1_q == $past(ptr1_q) + 16'h0001)
    else $error("autopointer one did not advance");

  // ****************************************
  // configuration and read mux
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      for (int i = 0; i < 4; i++) begin
        cfg_q[i] <= CFG_RST;
      end
    end else if (wr_lo && wa_q < OFS_COUNT_BASE) begin
      cfg_q[wa_q[3:2]] <= wd_q[7:0];
    end
  end

  always_comb begin
    logic [BC_W-1:0] c;
    c = '0;
    rofs = araddr - OFS_COUNT_BASE;
    rd_ok = 1'b1;
    rd_val = '0;
    if (araddr[1:0] != 2'h0) begin
      rd_ok = 1'b0;
    end else if (araddr < OFS_COUNT_BASE) begin
      rd_val = 32'(cfg_q[araddr[3:2]]);
    end else if (araddr < OFS_EP_STATUS) begin
      c = rofs[4] ? in_cnt_q[rofs[3]][in_wbuf_q[rofs[3]]]
                  : out_cnt_q[rofs[3]][out_rbuf_q[rofs[3]]];
      rd_val = rofs[2] ? 32'(c[7:0]) : 32'(c[BC_W-1:8]);
    end else begin
      case (araddr)
        OFS_EP_STATUS: rd_val = 32'(stat);
        OFS_NAK_EN: rd_val = {26'h0, ping_en_v, 3'h0, |in_en_v};
        OFS_NAK_REQ: rd_val = {26'h0, ping_req_v, 3'h0, |in_req_v};
        OFS_IN_NAK_EN: rd_val = 32'(in_en_v);
        OFS_IN_NAK_REQ: rd_val = 32'(in_req_v);
        OFS_APTR_SETUP: rd_val = 32'(aptr_setup_q);
        OFS_APTR_ONE: rd_val = 32'(ptr1_q);
        OFS_APTR_TWO: rd_val = 32'(ptr2_q);
        OFS_APTR_ONE_DATA: rd_val = 32'(mem[ap1_addr]);
        OFS_APTR_TWO_DATA: rd_val = '0;
        default: rd_ok = 1'b0;
      endcase
    end
  end

  // ****************************************
  // link transactions
  // ****************************************
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      lstate_q <= LINK_IDLE;
      lpair_q <= 1'b0;
      loff_q <= '0;
      lcnt_q <= '0;
      link_out_q <= '0;
    end else begin
      link_out_q.hs_valid <= 1'b0;
      link_out_q.in_valid <= 1'b0;
      link_out_q.in_last <= 1'b0;
      case (lstate_q)
        LINK_IDLE: begin
          if (link_in.tok_valid) begin
            lpair_q <= link_in.tok_pair;
            loff_q <= '0;
            link_out_q.hs_valid <= 1'b1;
            link_out_q.hs_code <= HS_NAK;
            case (link_in.tok_kind)
              TOK_OUT: begin
                if (out_avail_q[link_in.tok_pair] != 2'h0) begin
                  link_out_q.hs_code <= HS_ACK;
                  lstate_q <= LINK_RX;
                end else begin
                  lstate_q <= LINK_DROP;
                end
              end
              TOK_PING: begin
                if (out_avail_q[link_in.tok_pair] != 2'h0) begin
                  link_out_q.hs_code <= HS_ACK;
                end
              end
              TOK_IN: begin
                if (in_comm_q[link_in.tok_pair] != 2'h0) begin
                  link_out_q.hs_code <= HS_DATA;
                  lcnt_q <= in_cnt_q[link_in.tok_pair][in_rbuf_q[link_in.tok_pair]];
                  link_out_q.in_count <= in_cnt_q[link_in.tok_pair][in_rbuf_q[link_in.tok_pair]];
                  if (in_cnt_q[link_in.tok_pair][in_rbuf_q[link_in.tok_pair]] != '0) begin
                    lstate_q <= LINK_TX;
                  end
                end
              end
              default: begin
                link_out_q.hs_code <= HS_NAK;
              end
            endcase
          end
        end
        LINK_RX, LINK_DROP: begin
          if (link_in.byte_valid) begin
            loff_q <= loff_q + 10'(1);
            if (link_in.byte_last) begin
              lstate_q <= LINK_IDLE;
            end
          end
        end
        LINK_TX: begin
          link_out_q.in_valid <= 1'b1;
          link_out_q.in_data <= mem[tx_addr];
          link_out_q.in_last <= tx_last;
          loff_q <= loff_q + 10'(1);
          if (tx_last) begin
            lstate_q <= LINK_IDLE;
          end
        end
        default: lstate_q <= LINK_IDLE;
      endcase
    end
  end

  assign link_out = link_out_q;
endmodule // bulk_loop_endpoints

/* usb_host_model.sv */
`timescale 1ns/1ps
module usb_host_model (
  input wire logic aclk, // bus clock
  output bulk_loop_pkg::link_in_type link_in, // tokens and OUT bytes
  input wire bulk_loop_pkg::link_out_type link_out // handshakes and IN bytes
);
  import bulk_loop_pkg::*;
  // ****************
  // host transactions
  // ****************
  logic [7:0] rx[$];
  logic timed_out = 1'b0;
  initial link_in = '0;
  // code 3 stays when no handshake arrives
  task automatic tok(input tok_kind_type k, input logic p, output logic [1:0] h);
    int n;
    h = 2'h3;
    @(posedge aclk);
    link_in.tok_valid <= 1'b1;
    link_in.tok_kind <= k;
    link_in.tok_pair <= p;
    @(posedge aclk);
    link_in.tok_valid <= 1'b0;
    for (n = 0; n < 8; n++) begin
      @(posedge aclk);
      if (link_out.hs_valid) begin
        h = link_out.hs_code;
        break;
      end
    end
    if (n == 8) timed_out = 1'b1;
  endtask
  // bytes go out even after a refusal, as the wire protocol demands
  task automatic send_out(input logic p, input int len, input logic [7:0] b,
                          output logic [1:0] h);
    int i;
    tok(TOK_OUT, p, h);
    for (i = 0; i < len; i++) begin
      link_in.byte_valid <= 1'b1;
      link_in.byte_data <= 8'(b + i);
      link_in.byte_last <= (i == len - 1);
      @(posedge aclk);
    end
    link_in.byte_valid <= 1'b0;
    link_in.byte_last <= 1'b0;
    link_in.byte_data <= ~link_in.byte_data;
  endtask
  task automatic get_in(input logic p, output logic [1:0] h);
    int n;
    rx = {};
    tok(TOK_IN, p, h);
    for (n = 0; h == HS_DATA && n < 600; n++) begin
      if (link_out.in_valid) rx.push_back(link_out.in_data);
      if (link_out.in_valid && link_out.in_last) break;
      @(posedge aclk);
    end
    if (h == HS_DATA && n == 600) timed_out = 1'b1;
  endtask
endmodule // usb_host_model

/* testbench.sv */
`timescale 1ns/1ps
`define CHK(n, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module testbench;
  import bulk_loop_pkg::*;
  // ****************
  // bench signals
  // ****************
  typedef struct packed {logic we; logic [7:0] a; logic [31:0] d; logic [1:0] rs;} row_type;
  logic aclk = 0, aresetn = 0, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd;
  logic [3:0] wstrb = 4'hF;
  logic awready, wready, bvalid, arready, rvalid, irq;
  logic [1:0] bresp, rresp, rs, hs;
  link_in_type link_in;
  link_out_type link_out;
  int n_mismatch = 0, tests_run = 0, i;
  row_type rows[18] = '{'{1'b0, 8'h30, 32'h5F, 2'h0}, '{1'b0, 8'h44, 32'h01, 2'h0},
    '{1'b1, 8'h00, 32'hA2, 2'h0}, '{1'b1, 8'h04, 32'hA0, 2'h0}, '{1'b1, 8'h08, 32'hE2, 2'h0},
    '{1'b1, 8'h0C, 32'hE0, 2'h0}, '{1'b0, 8'h00, 32'hA2, 2'h0}, '{1'b0, 8'h0C, 32'hE0, 2'h0},
    '{1'b1, 8'h14, 32'h80, 2'h0}, '{1'b1, 8'h14, 32'h80, 2'h0}, '{1'b1, 8'h1C, 32'h80, 2'h0},
    '{1'b1, 8'h1C, 32'h80, 2'h0}, '{1'b0, 8'h30, 32'h55, 2'h0}, '{1'b1, 8'h30, 32'h00, 2'h0},
    '{1'b0, 8'h30, 32'h55, 2'h0}, '{1'b1, 8'h58, 32'h00, AXI_SLVERR},
    '{1'b0, 8'h58, 32'h00, AXI_SLVERR}, '{1'b0, 8'h02, 32'h00, AXI_SLVERR}};
  always #25 aclk = ~aclk;
  bulk_loop_endpoints i_bulk_loop_endpoints (.aclk, .aresetn, .awaddr, .awvalid, .awready,
    .wdata, .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready, .link_in, .link_out, .irq);
  usb_host_model i_usb_host_model (.aclk, .link_in, .link_out);
  // ****************
  // tasks
  // ****************
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
    if (n_mismatch == 0 && tests_run > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask
  task automatic acc(input logic we, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge aclk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= we;
    wvalid <= we;
    bready <= we;
    arvalid <= !we;
    rready <= !we;
    for (k = 0; k < 40; k++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (arvalid && arready) arvalid <= 1'b0;
      if (we ? bvalid : rvalid) begin
        rd = rdata;
        rs = we ? bresp : rresp;
        bready <= 1'b0;
        rready <= 1'b0;
        break;
      end
    end
    if (k == 40) begin
      n_mismatch++;
      stop_test();
    end
    if (we) repeat (2) @(posedge aclk);
  endtask
  // ****************
  // main sequence
  // ****************
  initial begin
    #2000000;
    n_mismatch++;
    stop_test();
  end
  // a host wait that ran out of its bound ends the run
  always @(posedge aclk) begin
    if (i_usb_host_model.timed_out) begin
      n_mismatch++;
      stop_test();
    end
  end
  initial begin
    repeat (16) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    `CHK("irq", 1'b0, irq);
    foreach (rows[r]) begin
      acc(rows[r].we, rows[r].a, rows[r].d);
      `CHK("resp", rows[r].rs, rs);
      if (!rows[r].we) `CHK("rdata", rows[r].d, rd);
    end
    $display("register rows done");
    i_usb_host_model.send_out(1'b0, 3, 8'h10, hs);
    `CHK("hs1", HS_ACK, hs);
    i_usb_host_model.send_out(1'b0, 2, 8'h20, hs);
    `CHK("hs2", HS_ACK, hs);
    i_usb_host_model.send_out(1'b0, 1, 8'h30, hs);
    `CHK("hs3", HS_NAK, hs);
    i_usb_host_model.tok(TOK_PING, 1'b0, hs);
    `CHK("ping", HS_NAK, hs);
    acc(1'b0, 8'h30, 32'h0);
    `CHK("out_full", 2'b10, rd[1:0]);
    `CHK("in_full", 1'b0, rd[5]);
    acc(1'b0, 8'h38, 32'h0);
    `CHK("ping_req", 1'b1, rd[PING_BIT]);
    acc(1'b0, 8'h14, 32'h0);
    `CHK("count", 8'h03, rd[7:0]);
    $display("fill test done");
    acc(1'b1, 8'h48, 32'h0000);
    acc(1'b1, 8'h4C, 32'h0400);
    for (i = 0; i < 3; i++) begin
      acc(1'b0, 8'h50, 32'h0);
      `CHK("copy", 8'(8'h10 + i), rd[7:0]);
      acc(1'b1, 8'h54, rd);
    end
    acc(1'b1, 8'h20, 32'h0);
    acc(1'b1, 8'h24, 32'h3);
    acc(1'b1, 8'h14, 32'h80);
    acc(1'b1, 8'h38, 32'h10);
    acc(1'b0, 8'h38, 32'h0);
    `CHK("ping_clr", 1'b0, rd[PING_BIT]);
    i_usb_host_model.tok(TOK_PING, 1'b0, hs);
    `CHK("ping2", HS_ACK, hs);
    i_usb_host_model.send_out(1'b0, 1, 8'h30, hs);
    `CHK("hs4", HS_ACK, hs);
    acc(1'b0, 8'h14, 32'h0);
    `CHK("count2", 8'h02, rd[7:0]);
    $display("copy test done");
    i_usb_host_model.get_in(1'b0, hs);
    `CHK("in_hs", HS_DATA, hs);
    `CHK("in_count", 10'd3, link_out.in_count);
    `CHK("in_len", 3, i_usb_host_model.rx.size());
    for (i = 0; i < i_usb_host_model.rx.size(); i++)
      `CHK("in_data", 8'(8'h10 + i), i_usb_host_model.rx[i]);
    i_usb_host_model.get_in(1'b0, hs);
    `CHK("in_nak", HS_NAK, hs);
    acc(1'b0, 8'h40, 32'h0);
    `CHK("in_req", 1'b1, rd[0]);
    acc(1'b0, 8'h38, 32'h0);
    `CHK("sum_req", 1'b1, rd[0]);
    `CHK("irq_off", 1'b0, irq);
    acc(1'b1, 8'h3C, 32'h1);
    `CHK("irq_on", 1'b1, irq);
    acc(1'b0, 8'h34, 32'h0);
    `CHK("sum_en", 1'b1, rd[0]);
    acc(1'b1, 8'h40, 32'h1);
    `CHK("irq_clr", 1'b0, irq);
    i_usb_host_model.tok(TOK_PING, 1'b0, hs);
    `CHK("ping3", HS_NAK, hs);
    acc(1'b1, 8'h34, 32'h10);
    `CHK("irq_ping", 1'b1, irq);
    i_usb_host_model.send_out(1'b1, 2, 8'h40, hs);
    `CHK("hs_b", HS_ACK, hs);
    acc(1'b0, 8'h1C, 32'h0);
    `CHK("count_b", 8'h02, rd[7:0]);
    $display("in nak test done");
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    acc(1'b0, 8'h30, 32'h0);
    `CHK("status_rst", 32'h5F, rd);
    `CHK("irq_rst", 1'b0, irq);
    $display("second reset test done");
    stop_test();
  end
endmodule // testbench
